// [iwd_decoder.sv]
// Instruction word decoder with four-phase cycle sequencer
`timescale 1ns/10ps
// Notes on behaviour
// [RL1] 14-bit words split into opcode and operand fields
// [RL2] Destination bit 0 writes accumulator, 1 writes file register
// [RL3] File operand is a 7-bit address, 0x00 to 0x7F
// [RL4] Bit operand picks one bit of the 8-bit file register
// [RL5] Literal operand is 8 or 11 bits depending on instruction
// [RL6] Don't-care bits never change the decoded operation
// [RL7] One cycle; two with NOP second cycle on true test or jump
// [RL8] Each instruction cycle is four oscillator periods
// [RL9] Byte group: 00, 4-bit op, destination bit, 7-bit address
// [RL10] Bit group: 01, 2-bit op, 3-bit bit number, 7-bit address
// [RL11] Read-modify-write of I/O reads the pins, not the latch
// [RL12] 11-bit constant only for call and jump; others use 8 bits
module iwd_decoder (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic [iwd_pkg::WORD_W-1:0]   instr_word,
  input  wire logic                         cond_true,
  input  wire logic                         pc_change,
  output logic                              fetch_req,
  output logic                              phase_last,
  output logic [1:0]                        q_phase,
  output logic                              flush_nop,
  output iwd_pkg::iwd_class_e               instr_class,
  output iwd_pkg::iwd_op_e                  op_kind,
  output logic [3:0]                        alu_code,
  output logic                              wr_accum,
  output logic                              wr_file,
  output logic [iwd_pkg::FADDR_W-1:0]       file_addr,
  output logic [7:0]                        bit_mask,
  output logic [iwd_pkg::LIT11_W-1:0]       literal,
  output logic                              lit_is_addr,
  output logic                              read_pins
);
  iwd_fields_if fl ();

  logic [iwd_pkg::WORD_W-1:0] word_q;
  logic [1:0]                 phase_q;
  logic                       nop_q;
  logic                       nop_d;
  iwd_pkg::iwd_class_e        cls_d;
  iwd_pkg::iwd_op_e           op_d;
  logic                       wacc_d;
  logic                       wfile_d;
  logic                       rmw_d;
  logic                       litaddr_d;

  // Flushed second cycle decodes as an all-zero word, a plain no-op
  logic [iwd_pkg::WORD_W-1:0] eff_word;
  assign eff_word = nop_q ? iwd_pkg::NOP_WORD : word_q; // [RL7]

  iwd_splitter u_split (
    .word (eff_word),
    .f    (fl)
  ); // [RL1]

  // Four oscillator periods per instruction cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= iwd_pkg::PHASE_RST;
    end else begin
      phase_q <= phase_q + 2'h1; // [RL8]
    end
  end

  assign phase_last = (phase_q == iwd_pkg::PHASE_LAST);
  assign fetch_req  = phase_last;
  assign q_phase    = phase_q;
  assign flush_nop  = nop_q;

  // Next word latched at end of cycle; taken branch inserts a NOP
  always_ff @(posedge clk) begin
    if (reset) begin
      word_q <= iwd_pkg::NOP_WORD;
    end else if (phase_last) begin
      word_q <= instr_word; // [RL1]
    end
  end

  always_comb begin
    nop_d = nop_q;
    if (phase_last) begin
      nop_d = !nop_q && (cond_true || pc_change); // [RL7]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nop_q <= 1'b0;
    end else begin
      nop_q <= nop_d;
    end
  end

  // Group and operation decode; don't-care bits are never compared
  always_comb begin
    cls_d     = iwd_pkg::IWD_CLS_BYTE;
    op_d      = iwd_pkg::IWD_OP_NONE;
    wacc_d    = 1'b0;
    wfile_d   = 1'b0;
    rmw_d     = 1'b0;
    litaddr_d = 1'b0;
    case (fl.group)
      iwd_pkg::GRP_BYTE: begin
        cls_d = iwd_pkg::IWD_CLS_BYTE; // [RL9]
        case (fl.op4)
          4'h0: begin
            if (fl.dest_file) begin
              op_d    = iwd_pkg::IWD_OP_MOVWF;
              wfile_d = 1'b1;
            end else if (eff_word[6:0] == 7'h08) begin
              op_d = iwd_pkg::IWD_OP_RETURN;
            end else if (eff_word[6:0] == 7'h09) begin
              op_d = iwd_pkg::IWD_OP_RETURN;
            end else if (eff_word[6:0] == 7'h63 ||
                         eff_word[6:0] == 7'h64) begin
              op_d = iwd_pkg::IWD_OP_CTRL;
            end else begin
              op_d = iwd_pkg::IWD_OP_NONE; // [RL6]
            end
          end
          4'h1: begin
            op_d    = iwd_pkg::IWD_OP_CLR;
            wacc_d  = !fl.dest_file; // [RL6]
            wfile_d = fl.dest_file;
          end
          default: begin
            op_d = (fl.op4 == 4'hB) ? iwd_pkg::IWD_OP_DECSZ :
                   (fl.op4 == 4'hF) ? iwd_pkg::IWD_OP_INCSZ :
                                      iwd_pkg::IWD_OP_ALU_F;
            wacc_d  = !fl.dest_file; // [RL2]
            wfile_d = fl.dest_file; // [RL2]
            rmw_d   = fl.dest_file; // [RL11]
          end
        endcase
      end
      iwd_pkg::GRP_BIT: begin
        cls_d = iwd_pkg::IWD_CLS_BIT; // [RL10]
        case (fl.op4[3:2])
          2'h0: begin
            op_d    = iwd_pkg::IWD_OP_BCLR;
            wfile_d = 1'b1;
            rmw_d   = 1'b1; // [RL11]
          end
          2'h1: begin
            op_d    = iwd_pkg::IWD_OP_BSET;
            wfile_d = 1'b1;
            rmw_d   = 1'b1; // [RL11]
          end
          2'h2:    op_d = iwd_pkg::IWD_OP_BTSC;
          default: op_d = iwd_pkg::IWD_OP_BTSS;
        endcase
      end
      iwd_pkg::GRP_JUMP: begin
        cls_d     = iwd_pkg::IWD_CLS_LIT;
        litaddr_d = 1'b1; // [RL12]
        op_d = fl.op4[3] ? iwd_pkg::IWD_OP_JUMP : iwd_pkg::IWD_OP_CALL;
      end
      default: begin
        cls_d  = iwd_pkg::IWD_CLS_LIT;
        wacc_d = 1'b1;
        // Bits 9:8 partly don't-care for move and return forms
        op_d = (fl.op4[3:2] == 2'h1) ? iwd_pkg::IWD_OP_RETLIT :
                                       iwd_pkg::IWD_OP_ALU_L; // [RL6]
      end
    endcase
  end

  // Literal width per group; jumps need all eleven address bits
  logic [iwd_pkg::LIT11_W-1:0] lit_d;
  always_comb begin
    lit_d = {3'h0, fl.lit8}; // [RL5]
    if (litaddr_d) begin
      lit_d = fl.lit11; // [RL12]
    end
  end

  // Decoded outputs registered so they hold stable across the cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      instr_class <= iwd_pkg::IWD_CLS_BYTE;
      op_kind     <= iwd_pkg::IWD_OP_NONE;
      alu_code    <= 4'h0;
    end else begin
      instr_class <= cls_d; // [RL1]
      op_kind     <= op_d;
      alu_code    <= fl.op4;
    end
  end

  // Write targets and the read-pins request travel together
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_accum  <= 1'b0;
      wr_file   <= 1'b0;
      read_pins <= 1'b0;
    end else begin
      wr_accum  <= wacc_d; // [RL2]
      wr_file   <= wfile_d; // [RL2]
      read_pins <= rmw_d; // [RL11]
    end
  end

  // File operand and bit selector
  always_ff @(posedge clk) begin
    if (reset) begin
      file_addr <= '0;
      bit_mask  <= 8'h00;
    end else begin
      file_addr <= fl.file_addr; // [RL3]
      bit_mask  <= (fl.group == iwd_pkg::GRP_BIT) ? fl.bit_mask
                                                  : 8'h00; // [RL4]
    end
  end

  // Constant operand
  always_ff @(posedge clk) begin
    if (reset) begin
      literal     <= '0;
      lit_is_addr <= 1'b0;
    end else begin
      literal     <= lit_d; // [RL5]
      lit_is_addr <= litaddr_d; // [RL12]
    end
  end
endmodule // iwd_decoder

// [iwd_pkg.sv]
// Shared constants and types for the instruction word decoder
package iwd_pkg;
  localparam int WORD_W     = 14;
  localparam int FADDR_W    = 7;
  localparam int BITSEL_W   = 3;
  localparam int LIT8_W     = 8;
  localparam int LIT11_W    = 11;
  localparam int QPHASES    = 4;
  localparam int FADDR_LSB  = 0;
  localparam int DEST_POS   = 7;
  localparam int BITSEL_LSB = 7;
  localparam int BOP_LSB    = 10;
  localparam int GRP_LSB    = 12;
  localparam int OP4_LSB    = 8;
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [13:0] NOP_WORD = 14'h0000;

  typedef enum logic [1:0] {
    IWD_CLS_BYTE,
    IWD_CLS_BIT,
    IWD_CLS_LIT
  } iwd_class_e;

  typedef enum logic [3:0] {
    IWD_OP_NONE, IWD_OP_ALU_F, IWD_OP_MOVWF, IWD_OP_CLR,
    IWD_OP_DECSZ, IWD_OP_INCSZ, IWD_OP_BCLR, IWD_OP_BSET,
    IWD_OP_BTSC, IWD_OP_BTSS, IWD_OP_CALL, IWD_OP_JUMP,
    IWD_OP_RETURN, IWD_OP_RETLIT, IWD_OP_ALU_L, IWD_OP_CTRL
  } iwd_op_e;
endpackage

// [iwd_fields_if.sv]
// Field bundle between the word splitter and the decoder
`timescale 1ns/10ps
interface iwd_fields_if;
  logic [1:0]                       group;
  logic [3:0]                       op4;
  logic                             dest_file;
  logic [iwd_pkg::FADDR_W-1:0]      file_addr;
  logic [iwd_pkg::BITSEL_W-1:0]     bit_num;
  logic [7:0]                       bit_mask;
  logic [iwd_pkg::LIT8_W-1:0]       lit8;
  logic [iwd_pkg::LIT11_W-1:0]      lit11;
  modport split (output group, op4, dest_file, file_addr, bit_num,
                 bit_mask, lit8, lit11);
  modport use_f (input group, op4, dest_file, file_addr, bit_num,
                 bit_mask, lit8, lit11);
endinterface

// [iwd_splitter.sv]
// Combinational splitting of one instruction word into fields
`timescale 1ns/10ps
module iwd_splitter (
  input  wire logic [iwd_pkg::WORD_W-1:0] word,
  iwd_fields_if.split                     f
);
  always_comb begin
    f.group     = word[iwd_pkg::GRP_LSB +: 2];
    f.op4       = word[iwd_pkg::OP4_LSB +: 4];
    f.dest_file = word[iwd_pkg::DEST_POS];
    f.file_addr = word[iwd_pkg::FADDR_LSB +: iwd_pkg::FADDR_W];
    f.bit_num   = word[iwd_pkg::BITSEL_LSB +: iwd_pkg::BITSEL_W];
    f.bit_mask  = 8'h01 << f.bit_num;
    f.lit8      = word[0 +: iwd_pkg::LIT8_W];
    f.lit11     = word[0 +: iwd_pkg::LIT11_W];
  end
endmodule // iwd_splitter

// [iwd_decoder_properties.sv]
// Port assertions for the instruction word decoder
`timescale 1ns/10ps
module iwd_decoder_checker (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic [13:0]      instr_word,
  input wire logic             cond_true,
  input wire logic             pc_change,
  input wire logic             fetch_req,
  input wire logic [1:0]       q_phase,
  input wire logic             flush_nop,
  input wire iwd_pkg::iwd_op_e op_kind,
  input wire logic             wr_file,
  input wire logic [6:0]       file_addr,
  input wire logic [7:0]       bit_mask,
  input wire logic [10:0]      literal,
  input wire logic             lit_is_addr,
  input wire logic             read_pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [13:0] w;
  logic        take;
  assign w = instr_word;
  // A word fetched in a flush slot still executes
  assign take = fetch_req && (flush_nop || !(cond_true || pc_change));
  AST_PHASE: assert property (!$past(reset) |->
    q_phase == $past(q_phase) + 2'h1 && fetch_req == (q_phase == 2'h3))
    else $error("phase count broken");
  // Word latched at the fetch edge, decoded outputs one edge later
  AST_BYTE: assert property (take && w[13:12] == 2'h0
    |-> ##2 (file_addr == $past(w[6:0], 2)))
    else $error("file address wrong");
  AST_DEST: assert property (take && w[13:11] == 3'h0 &&
    w[10:9] != 2'h0 |-> ##2 (wr_file == $past(w[7], 2) &&
    read_pins == $past(w[7], 2))) else $error("destination wrong");
  AST_MASK: assert property (take && w[13:12] == 2'h1
    |-> ##2 (bit_mask == 8'h01 << $past(w[9:7], 2)))
    else $error("bit mask wrong");
  AST_LIT11: assert property (take && w[13:12] == 2'h2
    |-> ##2 (lit_is_addr && literal == $past(w[10:0], 2)))
    else $error("long literal");
  AST_LIT8: assert property (take && w[13:12] == 2'h3
    |-> ##2 (!lit_is_addr && literal == {3'h0, $past(w[7:0], 2)}))
    else $error("short literal");
  AST_FLUSH: assert property (fetch_req && !flush_nop &&
    (cond_true || pc_change) |=> flush_nop [*4] ##1 !flush_nop)
    else $error("flush length");
  AST_FLUSH_OP: assert property (fetch_req && !flush_nop &&
    (cond_true || pc_change) |-> ##2 (op_kind == iwd_pkg::IWD_OP_NONE) [*4])
    else $error("flushed slot not idle");
  // New outputs first show in phase 1, then hold for the cycle
  AST_STAND: assert property (q_phase != 2'h1 |->
    $stable(literal) && $stable(file_addr) && $stable(op_kind))
    else $error("output moved");
  cover property (take && w[13:12] == 2'h1);
  cover property (take && w[13:12] == 2'h2);
  cover property (fetch_req && flush_nop);
  cover property (fetch_req && flush_nop && (cond_true || pc_change));
endmodule // iwd_decoder_checker
bind iwd_decoder iwd_decoder_checker u_chk (.clk, .reset, .instr_word,
  .cond_true, .pc_change, .fetch_req, .q_phase, .flush_nop, .op_kind,
  .wr_file, .file_addr, .bit_mask, .literal, .lit_is_addr, .read_pins);

// [iwd_prog_mem.sv]
// Program memory model feeding one word per fetch
`timescale 1ns/10ps
module iwd_prog_mem (
  input  wire logic   fetch_req,
  output logic [13:0] word
);
  logic [13:0] cur_q;
  // Bus is not held between fetches: show the inverse, not the old word
  assign word = fetch_req ? cur_q : ~cur_q;
endmodule // iwd_prog_mem

// [instruction_word_decoder_bench.sv]
// Self-checking bench for the instruction word decoder
`timescale 1ns/10ps
module instruction_word_decoder_bench;
  logic        clk, reset, cond_true, pc_change, fetch_req, flush_nop;
  logic        wr_accum, wr_file, lit_is_addr, read_pins, phase_last;
  logic [13:0] instr_word;
  logic [1:0]  q_phase;
  logic [3:0]  alu_code;
  logic [6:0]  file_addr;
  logic [7:0]  bit_mask;
  logic [10:0] literal;
  int          n_mismatch, n_checks, cycles;
  iwd_pkg::iwd_class_e instr_class;
  iwd_pkg::iwd_op_e    op_kind;
  iwd_decoder u_dut (.clk, .reset, .instr_word, .cond_true, .pc_change,
    .fetch_req, .phase_last, .q_phase, .flush_nop, .instr_class,
    .op_kind, .alu_code, .wr_accum, .wr_file, .file_addr, .bit_mask,
    .literal, .lit_is_addr, .read_pins);
  iwd_prog_mem u_mem (.fetch_req, .word(instr_word));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run needs under two hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [10:0] e, input logic [10:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task issue(input logic [13:0] w, input logic c, input logic p);
    while (fetch_req !== 1'b1) @(negedge clk);
    u_mem.cur_q = w;
    cond_true = c;
    pc_change = p;
    @(negedge clk);
    cond_true = 1'b0;
    pc_change = 1'b0;
    // Decoded outputs register one clock after the word is taken
    @(negedge clk);
  endtask
  task t_byte();
    logic [3:0] op;
    for (int i = 0; i < 4; i++) begin
      op = i[1] ? 4'hF : 4'h7;
      issue({2'h0, op, i[0], {7{i[0]}}}, 1'b0, 1'b0);
      chk("file_addr", 11'({7{i[0]}}), 11'(file_addr));
      chk("alu_code", 11'(op), 11'(alu_code));
      chk("wr_file", 11'(i[0]), 11'(wr_file));
      chk("wr_accum", 11'(!i[0]), 11'(wr_accum));
      chk("read_pins", 11'(i[0]), 11'(read_pins));
    end
  endtask
  task t_special();
    logic [13:0]      w [13] = '{14'h00FF, 14'h0008, 14'h0009, 14'h0063,
      14'h0064, 14'h0060, 14'h017F, 14'h0185, 14'h0B85, 14'h1005,
      14'h1805, 14'h3700, 14'h2000};
    // Expected writes: bit 1 accumulator, bit 0 file register
    logic [1:0]       a [13] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
      2'h2, 2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h0};
    iwd_pkg::iwd_op_e o [13] = '{iwd_pkg::IWD_OP_MOVWF,
      iwd_pkg::IWD_OP_RETURN, iwd_pkg::IWD_OP_RETURN, iwd_pkg::IWD_OP_CTRL,
      iwd_pkg::IWD_OP_CTRL, iwd_pkg::IWD_OP_NONE, iwd_pkg::IWD_OP_CLR,
      iwd_pkg::IWD_OP_CLR, iwd_pkg::IWD_OP_DECSZ, iwd_pkg::IWD_OP_BCLR,
      iwd_pkg::IWD_OP_BTSC, iwd_pkg::IWD_OP_RETLIT, iwd_pkg::IWD_OP_CALL};
    for (int i = 0; i < 13; i++) begin
      issue(w[i], 1'b0, 1'b0);
      chk("op_kind", 11'(o[i]), 11'(op_kind));
      chk("wr_flags", 11'(a[i]), 11'({wr_accum, wr_file}));
    end
  endtask
  task t_bit();
    for (int b = 0; b < 8; b++) begin
      issue({4'h5, b[2:0], 7'h15}, 1'b0, 1'b0);
      chk("bit_mask", 11'(8'h01 << b), 11'(bit_mask));
      chk("op_kind", 11'(iwd_pkg::IWD_OP_BSET), 11'(op_kind));
    end
  endtask
  task t_lit();
    logic [13:0]      w [4] = '{14'h27FF, 14'h2C00, 14'h30A5, 14'h33A5};
    logic [10:0]      k [4] = '{11'h7FF, 11'h400, 11'h0A5, 11'h0A5};
    iwd_pkg::iwd_op_e o [4] = '{iwd_pkg::IWD_OP_CALL, iwd_pkg::IWD_OP_JUMP,
      iwd_pkg::IWD_OP_ALU_L, iwd_pkg::IWD_OP_ALU_L};
    for (int i = 0; i < 4; i++) begin
      issue(w[i], 1'b0, 1'b0);
      chk("literal", k[i], literal);
      chk("lit_is_addr", 11'(i < 2), 11'(lit_is_addr));
      chk("class", 11'(iwd_pkg::IWD_CLS_LIT), 11'(instr_class));
      chk("op_kind", 11'(o[i]), 11'(op_kind));
    end
  endtask
  task t_flush(input logic c, input logic p);
    issue(14'h1D85, 1'b0, 1'b0);
    // Jump word fetched here is discarded by the flush
    issue(14'h2C00, c, p);
    for (int k = 0; k < 3; k++) begin
      chk("flush_nop", 11'h001, 11'(flush_nop));
      chk("op_kind", 11'(iwd_pkg::IWD_OP_NONE), 11'(op_kind));
      if (k < 2) @(negedge clk);
    end
    // Flags raised in the flush slot are refused
    issue(14'h1D85, c, p);
    chk("flush_nop", 11'h000, 11'(flush_nop));
    chk("op_kind", 11'(iwd_pkg::IWD_OP_BTSS), 11'(op_kind));
  endtask
  task t_reset();
    int n;
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    chk("q_phase", 11'(iwd_pkg::PHASE_RST), 11'(q_phase));
    chk("op_kind", 11'(iwd_pkg::IWD_OP_NONE), 11'(op_kind));
    chk("flush_nop", 11'h000, 11'(flush_nop));
    reset = 1'b0;
    n = 0;
    while (fetch_req !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    chk("fetch_delay", 11'(iwd_pkg::PHASE_LAST), 11'(n));
    for (int k = 1; k <= 4; k++) begin
      @(negedge clk);
      chk("fetch_req", 11'(k == 4), 11'(fetch_req));
      chk("phase_last", 11'(k == 4), 11'(phase_last));
    end
  endtask
  initial begin
    reset = 1'b1;
    cond_true = 1'b0;
    pc_change = 1'b0;
    u_mem.cur_q = 14'h0000;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_byte();
    t_special();
    t_bit();
    t_lit();
    t_flush(1'b1, 1'b0);
    t_flush(1'b0, 1'b1);
    t_reset();
    complete_run();
  end
endmodule // instruction_word_decoder_bench
